/* File: shared/i2c_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface i2c_link_if;
	logic scl_o_m;
	logic scl_oe_m;
	logic sda_o_m;
	logic sda_oe_m;
	logic scl_o_s;
	logic scl_oe_s;
	logic sda_o_s;
	logic sda_oe_s;
	logic scl;
	logic sda;
	// Open drain wired-AND with pull-up
	assign scl = !((scl_oe_m && !scl_o_m) || (scl_oe_s && !scl_o_s));
	assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));
	modport master (input scl, input sda, output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m);
	modport slave  (input scl, input sda, output scl_o_s, output scl_oe_s, output sda_o_s, output sda_oe_s);
endinterface
`default_nettype wire

/* File: shared/i2c_slave_pkg.sv */
`default_nettype none
package i2c_slave_pkg;
	// ------------------------------------------------------------
	// Register map of the slave (software port)
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_CTRL_A   = 3'h0;
	localparam logic [2:0] ADDR_CTRL_B   = 3'h1;
	localparam logic [2:0] ADDR_OWN      = 3'h2;
	localparam logic [2:0] ADDR_DATA     = 3'h3;
	// ctrl_a fields
	localparam int         CA_MODE_LSB   = 5;
	localparam logic [2:0] MODE_TWO_WIRE = 3'h6;
	localparam int         CA_ENABLE     = 1;
	localparam int         CA_IRQ_EN     = 0;
	// ctrl_b fields
	localparam int         CB_XFER_DONE  = 7;
	localparam int         CB_ADDR_MATCH = 6;
	localparam int         CB_BUSY       = 5;
	localparam int         CB_TX_MODE    = 4;
	localparam int         CB_ACK_OUT    = 3;
	localparam int         CB_MREAD      = 2;
	localparam int         CB_ACK_IN     = 0;
	// ------------------------------------------------------------
	// Master port commands
	// ------------------------------------------------------------
	localparam logic [1:0] CMD_START     = 2'h0;
	localparam logic [1:0] CMD_WRITE     = 2'h1;
	localparam logic [1:0] CMD_READ      = 2'h2;
	localparam logic [1:0] CMD_STOP      = 2'h3;
	// Link clock: 80 ns period at 100 MHz, half period 4 cycles
	localparam int         SYS_CLK_MHZ   = 100;
	localparam int         LINK_PERIOD_NS = 80;
	localparam int         HALF_CYCLES   = (LINK_PERIOD_NS * SYS_CLK_MHZ) / 2000;
endpackage
`default_nettype wire

/* File: src/i2c_master.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_master (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [1:0] cmd,
	input  wire logic [7:0] cmd_data,
	input  wire logic       cmd_ack,
	input  wire logic       cmd_valid,
	output logic            busy,
	output logic            done,
	output logic      [7:0] rx_data,
	output logic            rx_ack,
	i2c_link_if.master      link
);
	typedef enum logic [2:0] {IDLE, ST_A, ST_B, BIT_LO, BIT_HI, SP_A, SP_B} state_t;
	state_t     state_r;
	logic [1:0] cmd_r;
	logic [8:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] div_r;
	logic       scl_drv_r;
	logic       sda_drv_r;
	logic [1:0] scl_s_r;
	logic [1:0] sda_s_r;
	logic       tick;

	// ------------------------------------------------------------
	// Clock divider and pin sampling
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
		end else begin
			scl_s_r <= {scl_s_r[0], link.scl};
			sda_s_r <= {sda_s_r[0], link.sda};
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst || state_r == IDLE) begin
			div_r <= 8'h00;
		end else if (scl_drv_r && !scl_s_r[1]) begin
			div_r <= 8'h00; // Slave stretches clock
		end else if (tick) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end
	assign tick = (div_r == 8'(i2c_slave_pkg::HALF_CYCLES - 1));

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r   <= IDLE;
			cmd_r     <= 2'h0;
			shift_r   <= 9'h1FF;
			bit_cnt_r <= 4'h0;
			scl_drv_r <= 1'b1;
			sda_drv_r <= 1'b1;
			busy      <= 1'b0;
			done      <= 1'b0;
			rx_data   <= 8'h00;
			rx_ack    <= 1'b1;
		end else begin
			done <= 1'b0;
			unique case (state_r)
				IDLE: if (cmd_valid) begin
					busy      <= 1'b1;
					cmd_r     <= cmd;
					bit_cnt_r <= 4'h0;
					shift_r   <= (cmd == i2c_slave_pkg::CMD_READ) ? {8'hFF, cmd_ack} : {cmd_data, 1'b1};
					unique case (cmd)
						i2c_slave_pkg::CMD_START: begin
							sda_drv_r <= 1'b1;
							scl_drv_r <= 1'b1;
							state_r   <= ST_A;
						end
						i2c_slave_pkg::CMD_STOP: begin
							sda_drv_r <= 1'b0;
							state_r   <= SP_A;
						end
						default: state_r <= BIT_LO;
					endcase
				end
				ST_A: if (tick) begin
					sda_drv_r <= 1'b0;
					state_r   <= ST_B;
				end
				ST_B: if (tick) begin
					scl_drv_r <= 1'b0;
					busy      <= 1'b0;
					done      <= 1'b1;
					state_r   <= IDLE;
				end
				BIT_LO: begin
					if (div_r == 8'h00) sda_drv_r <= shift_r[8];
					if (tick) begin
						scl_drv_r <= 1'b1;
						state_r   <= BIT_HI;
					end
				end
				BIT_HI: if (tick && scl_s_r[1]) begin
					scl_drv_r <= 1'b0;
					shift_r   <= {shift_r[7:0], sda_s_r[1]};
					bit_cnt_r <= bit_cnt_r + 4'h1;
					if (bit_cnt_r == 4'h8) begin
						rx_data   <= shift_r[7:0];
						rx_ack    <= sda_s_r[1];
						sda_drv_r <= 1'b1;
						busy      <= 1'b0;
						done      <= 1'b1;
						state_r   <= IDLE;
					end else begin
						state_r <= BIT_LO;
					end
				end
				SP_A: if (tick) begin
					scl_drv_r <= 1'b1;
					state_r   <= SP_B;
				end
				SP_B: if (tick) begin
					sda_drv_r <= 1'b1;
					busy      <= 1'b0;
					done      <= 1'b1;
					state_r   <= IDLE;
				end
				default: state_r <= IDLE;
			endcase
		end
	end

	assign link.scl_o_m  = 1'b0;
	assign link.scl_oe_m = !scl_drv_r;
	assign link.sda_o_m  = 1'b0;
	assign link.sda_oe_m = !sda_drv_r;
endmodule // i2c_master
`default_nettype wire

/* File: src/i2c_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_slave (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            irq,
	i2c_link_if.slave       link
);
	typedef enum logic [2:0] {IDLE, ADDR, ACK, HOLD, RX, TX, ACK_TX, WAIT_STOP} state_t;
	state_t     state_r;
	logic [2:0] mode_r;
	logic       enable_r;
	logic       irq_en_r;
	logic [7:1] own_address_reg_r;
	logic [7:0] serial_data_reg_r;
	logic [7:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic       bus_busy_flag_r;
	logic       addr_match_flag_r;
	logic       master_read_flag_r;
	logic       tx_mode_bit_r;
	logic       ack_out_bit_r;
	logic       ack_in_flag_r;
	logic       xfer_done_flag_r;
	logic       irq_pend_r;
	logic       scl_hold_r;
	logic       sda_low_r;
	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic       active;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       data_wr;
	logic       data_rd;
	logic [7:0] ctrl_b;

	// ------------------------------------------------------------
	// Pin synchronisers and condition detection
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
		end else begin
			scl_s_r <= {scl_s_r[1:0], link.scl};
			sda_s_r <= {sda_s_r[1:0], link.sda};
		end
	end
	assign active    = enable_r && (mode_r == i2c_slave_pkg::MODE_TWO_WIRE);
	assign scl_rise  = scl_s_r[1] && !scl_s_r[2];
	assign scl_fall  = !scl_s_r[1] && scl_s_r[2];
	assign start_det = active && scl_s_r[1] && scl_s_r[2] && !sda_s_r[1] && sda_s_r[2];
	assign stop_det  = active && scl_s_r[1] && scl_s_r[2] && sda_s_r[1] && !sda_s_r[2];
	assign data_wr   = wr && (addr == i2c_slave_pkg::ADDR_DATA);
	assign data_rd   = rd && (addr == i2c_slave_pkg::ADDR_DATA);
	assign ctrl_b    = {xfer_done_flag_r, addr_match_flag_r, bus_busy_flag_r, tx_mode_bit_r,
			ack_out_bit_r, master_read_flag_r, 1'b0, ack_in_flag_r};

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_r            <= 3'h0;
			enable_r          <= 1'b0;
			irq_en_r          <= 1'b0;
			own_address_reg_r <= 7'h00;
			tx_mode_bit_r     <= 1'b0;
			ack_out_bit_r     <= 1'b0;
		end else if (wr) begin
			unique case (addr)
				i2c_slave_pkg::ADDR_CTRL_A: begin
					mode_r   <= wdata[i2c_slave_pkg::CA_MODE_LSB +: 3];
					enable_r <= wdata[i2c_slave_pkg::CA_ENABLE];
					irq_en_r <= wdata[i2c_slave_pkg::CA_IRQ_EN];
				end
				i2c_slave_pkg::ADDR_CTRL_B: begin
					tx_mode_bit_r <= wdata[i2c_slave_pkg::CB_TX_MODE];
					ack_out_bit_r <= wdata[i2c_slave_pkg::CB_ACK_OUT];
				end
				i2c_slave_pkg::ADDR_OWN: own_address_reg_r <= wdata[7:1];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				i2c_slave_pkg::ADDR_CTRL_A: rdata <= {mode_r, 3'h0, enable_r, irq_en_r};
				i2c_slave_pkg::ADDR_CTRL_B: rdata <= ctrl_b;
				i2c_slave_pkg::ADDR_OWN:    rdata <= {own_address_reg_r, 1'b0};
				i2c_slave_pkg::ADDR_DATA:   rdata <= serial_data_reg_r;
				default:                    rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Bus busy flag
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst || !active) begin
			bus_busy_flag_r <= 1'b0;
		end else if (start_det) begin
			bus_busy_flag_r <= 1'b1;
		end else if (stop_det) begin
			bus_busy_flag_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Slave protocol engine (slave only, never drives START)
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst || !active) begin
			state_r            <= IDLE;
			bit_cnt_r          <= 4'h0;
			shift_r            <= 8'h00;
			serial_data_reg_r  <= 8'h00;
			addr_match_flag_r  <= 1'b0;
			master_read_flag_r <= 1'b0;
			ack_in_flag_r      <= 1'b0;
			xfer_done_flag_r   <= 1'b1;
			irq_pend_r         <= 1'b0;
			scl_hold_r         <= 1'b0;
			sda_low_r          <= 1'b0;
		end else begin
			irq_pend_r <= 1'b0;
			if (data_wr) serial_data_reg_r <= wdata;
			if (start_det) begin
				state_r           <= ADDR;
				bit_cnt_r         <= 4'h0;
				addr_match_flag_r <= 1'b0;
				scl_hold_r        <= 1'b0;
				sda_low_r         <= 1'b0;
			end else if (stop_det) begin
				state_r    <= IDLE;
				scl_hold_r <= 1'b0;
				sda_low_r  <= 1'b0;
			end else begin
				unique case (state_r)
					IDLE: ;
					ADDR, RX: if (scl_rise) begin
						shift_r   <= {shift_r[6:0], sda_s_r[1]};
						bit_cnt_r <= bit_cnt_r + 4'h1;
						xfer_done_flag_r <= 1'b0;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						bit_cnt_r <= 4'h0;
						if (state_r == ADDR) begin
							if (shift_r[7:1] == own_address_reg_r) begin
								master_read_flag_r <= shift_r[0];
								addr_match_flag_r  <= 1'b1;
								irq_pend_r         <= 1'b1;
								sda_low_r          <= 1'b1;
								state_r            <= ACK;
							end else begin
								state_r <= WAIT_STOP;
							end
						end else begin
							serial_data_reg_r <= shift_r;
							xfer_done_flag_r  <= 1'b1;
							irq_pend_r        <= 1'b1;
							sda_low_r         <= !ack_out_bit_r;
							state_r           <= ACK;
						end
					end
					ACK: if (scl_fall) begin
						sda_low_r  <= 1'b0;
						scl_hold_r <= 1'b1;
						state_r    <= HOLD;
					end
					HOLD: if (data_wr || data_rd) begin
						addr_match_flag_r <= 1'b0;
						scl_hold_r        <= 1'b0;
						xfer_done_flag_r  <= 1'b0;
						if (tx_mode_bit_r) begin
							shift_r   <= data_wr ? wdata : serial_data_reg_r;
							sda_low_r <= data_wr ? !wdata[7] : !serial_data_reg_r[7];
							bit_cnt_r <= 4'h1;
							state_r   <= TX;
						end else begin
							state_r <= RX;
						end
					end
					TX: if (scl_fall) begin
						if (bit_cnt_r == 4'h8) begin
							sda_low_r <= 1'b0;
							state_r   <= ACK_TX;
						end else begin
							sda_low_r <= !shift_r[3'h7 - bit_cnt_r[2:0]];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
					ACK_TX: if (scl_rise) begin
						ack_in_flag_r    <= sda_s_r[1];
						xfer_done_flag_r <= 1'b1;
						irq_pend_r       <= 1'b1;
						bit_cnt_r        <= 4'h0;
						state_r          <= sda_s_r[1] ? WAIT_STOP : ACK;
					end
					WAIT_STOP: sda_low_r <= 1'b0;
					default: state_r <= IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_pend_r && irq_en_r;
		end
	end

	assign link.scl_o_s  = 1'b0;
	assign link.scl_oe_s = scl_hold_r;
	assign link.sda_o_s  = 1'b0;
	assign link.sda_oe_s = sda_low_r;
endmodule // i2c_slave
`default_nettype wire

/* File: test/i2c_link_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_link_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_oe_s,
	input wire logic sda_oe_s,
	input wire logic sda_oe_m
);
	logic       scl_q_r;
	logic [3:0] cnt_r;
	logic       first_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		scl_q_r <= rst ? 1'b1 : scl;
	end

	always_ff @(posedge sys_clk) begin
		if (rst || (scl && $fell(sda)))
			cnt_r <= 4'h0;
		else if (scl && !scl_q_r && cnt_r != 4'hF)
			cnt_r <= cnt_r + 4'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst || (scl && $rose(sda)) || cnt_r == 4'h9)
			first_r <= 1'b0;
		else if (scl && $fell(sda))
			first_r <= 1'b1;
	end

	sequence start_s;
		scl && $past(scl) && $fell(sda);
	endsequence

	sequence stop_s;
		scl && $past(scl) && $rose(sda);
	endsequence

	// ------------------------------------------------------------
	// Link assertions
	// ------------------------------------------------------------
	start_master_a : assert property (start_s |-> sda_oe_m && !sda_oe_s)
		else $error("start not made by master");
	addr_quiet_a : assert property (first_r && cnt_r < 4'h8 |-> !sda_oe_s && !scl_oe_s)
		else $error("slave drove link during address");
	ack_slot_a : assert property ($rose(sda_oe_s) && first_r |-> cnt_r == 4'h8)
		else $error("address ack outside ninth bit");
	data_low_a : assert property ($changed(sda_oe_s) |-> !scl)
		else $error("slave data changed while clock high");
	ack_held_a : assert property ($rose(scl) && sda_oe_s |-> sda_oe_s [*3])
		else $error("slave low bit not held over clock high");
	stretch_low_a : assert property ($rose(scl_oe_s) |-> !scl)
		else $error("slave cut a clock high phase");
	stretch_hold_a : assert property ($rose(scl_oe_s) |=> scl_oe_s [*2])
		else $error("clock hold released at once");
	stop_release_a : assert property (stop_s |-> ##1 (!sda_oe_s && !scl_oe_s) [*4])
		else $error("slave drove link after stop");
endmodule // i2c_link_chk
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic       rw;
		logic [6:0] adr;
		logic [7:0] dat;
		logic       ack;
	} row_t;
	localparam logic [7:0] OWN_REG = 8'h5B;
	logic       sys_clk;
	logic       rst;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       irq;
	logic [1:0] cmd;
	logic [7:0] cmd_data;
	logic       cmd_ack;
	logic       cmd_valid;
	logic       busy;
	logic       done;
	logic [7:0] rx_data;
	logic       rx_ack;
	logic [7:0] rb;
	int         fail_count;
	int         check_count;
	row_t       rows [4];

	i2c_link_if link ();
	i2c_slave i2c_slave_inst (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .link(link));
	i2c_master i2c_master_inst (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
		.cmd_valid(cmd_valid), .busy(busy), .done(done), .rx_data(rx_data), .rx_ack(rx_ack), .link(link));
	i2c_link_chk chk_inst (.sys_clk(sys_clk), .rst(rst), .scl(link.scl), .sda(link.sda), .scl_oe_s(link.scl_oe_s),
		.sda_oe_s(link.sda_oe_s), .sda_oe_m(link.sda_oe_m));

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic bad(input string msg);
		fail_count++;
		$display("BAD %0t %s", $time, msg);
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
			bad($sformatf("byte %h expected %h", got, exp));
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
			bad($sformatf("bit %b expected %b", got, exp));
	endtask
	task automatic results;
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 rb = rdata;
	endtask
	task automatic m_cmd(input logic [1:0] c, input logic [7:0] d, input logic a);
		@(posedge sys_clk);
		cmd <= c;
		cmd_data <= d;
		cmd_ack <= a;
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic wait_ev(input logic use_irq);
		for (int i = 0; i < 4000; i++) begin
			@(posedge sys_clk);
			if ((use_irq ? irq : done) === 1'b1)
				return;
		end
		bad("wait ran out");
		results();
	endtask

	// ------------------------------------------------------------
	// One whole transfer
	// ------------------------------------------------------------
	task automatic xfer(input row_t r);
		logic hit;
		hit = (r.adr == OWN_REG[7:1]);
		m_cmd(i2c_slave_pkg::CMD_START, 8'h00, 1'b1);
		wait_ev(1'b0);
		reg_rd(i2c_slave_pkg::ADDR_CTRL_B);
		chk_bit(rb[i2c_slave_pkg::CB_BUSY], 1'b1);
		m_cmd(i2c_slave_pkg::CMD_WRITE, {r.adr, r.rw}, 1'b1);
		if (hit)
			wait_ev(1'b1);
		wait_ev(1'b0);
		chk_bit(rx_ack, !hit);
		if (hit) begin
			reg_rd(i2c_slave_pkg::ADDR_CTRL_B);
			chk_bit(rb[i2c_slave_pkg::CB_ADDR_MATCH], 1'b1);
			chk_bit(rb[i2c_slave_pkg::CB_MREAD], r.rw);
			reg_wr(i2c_slave_pkg::ADDR_CTRL_B, {3'h0, r.rw, r.ack, 3'h0});
			chk_bit(link.scl_oe_s, 1'b1);
			if (r.rw)
				reg_wr(i2c_slave_pkg::ADDR_DATA, r.dat);
			else
				reg_rd(i2c_slave_pkg::ADDR_DATA);
		end
		if (hit && !r.rw) begin
			m_cmd(i2c_slave_pkg::CMD_WRITE, r.dat, 1'b1);
			repeat (10) @(posedge sys_clk);
			reg_rd(i2c_slave_pkg::ADDR_CTRL_B);
			chk_bit(rb[i2c_slave_pkg::CB_XFER_DONE], 1'b0);
			wait_ev(1'b1);
			wait_ev(1'b0);
			chk_bit(rx_ack, r.ack);
			repeat (4) @(posedge sys_clk);
			chk_bit(link.scl_oe_s, 1'b1);
			reg_rd(i2c_slave_pkg::ADDR_DATA);
			chk_byte(rb, r.dat);
			chk_bit(link.scl_oe_s, 1'b0);
		end
		if (hit && r.rw) begin
			m_cmd(i2c_slave_pkg::CMD_READ, 8'h00, r.ack);
			wait_ev(1'b0);
			chk_byte(rx_data, r.dat);
			reg_rd(i2c_slave_pkg::ADDR_CTRL_B);
			chk_bit(rb[i2c_slave_pkg::CB_ACK_IN], r.ack);
			chk_bit(rb[i2c_slave_pkg::CB_XFER_DONE], 1'b1);
		end
		m_cmd(i2c_slave_pkg::CMD_STOP, 8'h00, 1'b1);
		wait_ev(1'b0);
		repeat (4) @(posedge sys_clk);
		reg_rd(i2c_slave_pkg::ADDR_CTRL_B);
		chk_bit(rb[i2c_slave_pkg::CB_BUSY], 1'b0);
	endtask

	// ------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		fail_count = 0;
		check_count = 0;
		rst = 1'b1;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		cmd = 2'h0;
		cmd_data = 8'h00;
		cmd_ack = 1'b1;
		cmd_valid = 1'b0;
		rows[0] = {1'b0, OWN_REG[7:1], 8'hA5, 1'b0};
		rows[1] = {1'b0, OWN_REG[7:1], 8'h01, 1'b1};
		rows[2] = {1'b1, OWN_REG[7:1], 8'h96, 1'b1};
		rows[3] = {1'b0, OWN_REG[7:1] ^ 7'h01, 8'h00, 1'b1};
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		reg_rd(i2c_slave_pkg::ADDR_CTRL_B);
		chk_bit(rb[i2c_slave_pkg::CB_XFER_DONE], 1'b1);
		chk_bit(rb[i2c_slave_pkg::CB_BUSY], 1'b0);
		chk_bit(busy, 1'b0);
		chk_bit(rx_ack, 1'b1);
		reg_wr(i2c_slave_pkg::ADDR_OWN, OWN_REG);
		reg_wr(i2c_slave_pkg::ADDR_CTRL_A, {i2c_slave_pkg::MODE_TWO_WIRE, 5'h02});
		reg_wr(i2c_slave_pkg::ADDR_CTRL_A, {i2c_slave_pkg::MODE_TWO_WIRE, 5'h03});
		reg_rd(i2c_slave_pkg::ADDR_CTRL_A);
		chk_byte(rb, {i2c_slave_pkg::MODE_TWO_WIRE, 5'h03});
		reg_rd(3'h5);
		chk_byte(rb, 8'h00);
		for (int i = 0; i < 3; i++)
			xfer(rows[i]);
		xfer(rows[3]);
		results();
	end
endmodule // tb_top
`default_nettype wire
